// file: dbbr_core.sv
// Command decode, bank state, bursts and refresh of a DDR3 memory core.
// Behaviour
// - ACTIVE opens the given row in the bank chosen by bank address.
// - PRECHARGE closes one bank, or all banks when A10 is high.
// - Reads and writes to other banks proceed during auto precharge.
// - Precharge to an idle or closing bank is accepted; last restarts timing.
// - With on-the-fly mode A12 low chops to four, high gives eight.
// - A12 never forms part of the column address.
// - Read data timing holds only while the delay-locked loop is locked.
// - Write setup or hold errors corrupt only the addressed location.
// - Strobe timing errors stay local and never hang the device.
// - Writes are length eight for fixed eight, or on-the-fly with A12 high.
// - CS, RAS, CAS low with WE high starts a refresh cycle from idle; it is ignored during a burst.
// - Refresh rows come from an internal counter; address bus ignored.
// - After refresh every bank is precharged and idle.
module dbbr_core (
  input wire logic clock,
  input wire logic reset,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dbbr_pkg::BANK_W-1:0] bank_addr,
  input wire logic [dbbr_pkg::ADDR_W-1:0] addr,
  input wire logic [1:0] burst_mode,
  input wire logic [dbbr_pkg::LAT_W-1:0] cas_latency,
  input wire logic [dbbr_pkg::LAT_W-1:0] cas_write_latency,
  input wire logic [dbbr_pkg::LAT_W-1:0] additive_latency,
  input wire logic dll_locked,
  input wire logic [dbbr_pkg::DATA_W-1:0] wr_data,
  input wire logic [dbbr_pkg::DATA_W-1:0] rd_data_mem,
  output logic [dbbr_pkg::NUM_BANKS-1:0] bank_open,
  output logic refresh_busy,
  output logic [dbbr_pkg::ROW_W-1:0] refresh_row,
  output logic mem_rd,
  output logic mem_wr,
  output logic [dbbr_pkg::BANK_W-1:0] mem_bank,
  output logic [dbbr_pkg::ROW_W-1:0] mem_row,
  output logic [dbbr_pkg::COL_W-1:0] mem_col,
  output logic [dbbr_pkg::DATA_W-1:0] mem_wr_data,
  output logic rd_valid,
  output logic rd_timing_ok,
  output logic [dbbr_pkg::DATA_W-1:0] rd_data
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic cmd_act;
  logic cmd_pre;
  logic cmd_rd;
  logic cmd_wr;
  logic cmd_ref;
  logic pre_all;
  logic auto_pre;
  logic [3:0] burst_len;
  logic [dbbr_pkg::LAT_W-1:0] latency;
  logic [dbbr_pkg::NUM_BANKS-1:0] bank_sel;
  logic [dbbr_pkg::NUM_BANKS-1:0] bank_ready;
  logic [dbbr_pkg::ROW_W-1:0] open_rows [dbbr_pkg::NUM_BANKS];
  logic [dbbr_pkg::NUM_BANKS-1:0] bank_open_w;
  dbbr_pkg::dbbr_state_t state_reg;
  dbbr_pkg::dbbr_state_t state_next;

  // Picks the burst length from the mode field and A12 at the command.
  function automatic logic [3:0] dbbr_burst(input logic [1:0] mode, input logic bc);
    logic [3:0] len;
    len = dbbr_pkg::BURST_LEN4;
    if (mode == dbbr_pkg::BURST_FIXED8 || (mode == dbbr_pkg::BURST_OTF && bc)) begin
      len = dbbr_pkg::BURST_LEN8;
    end
    return len;
  endfunction : dbbr_burst

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign cmd_act = cke && cmd == dbbr_pkg::CMD_ACT && state_reg != dbbr_pkg::DBBR_REFRESH;
  assign cmd_pre = cke && cmd == dbbr_pkg::CMD_PRE;
  assign cmd_ref = cke && cmd == dbbr_pkg::CMD_REF;
  assign cmd_rd = cke && cmd == dbbr_pkg::CMD_RD && bank_open_w[bank_addr];
  assign cmd_wr = cke && cmd == dbbr_pkg::CMD_WR && bank_open_w[bank_addr];
  assign pre_all = addr[dbbr_pkg::AP_BIT];
  assign auto_pre = addr[dbbr_pkg::AP_BIT];
  assign burst_len = dbbr_burst(burst_mode, addr[dbbr_pkg::BC_BIT]);
  // Read latency is AL+CL and write latency AL+CWL, from the command edge.
  assign latency = cmd_rd ? additive_latency + cas_latency :
                   additive_latency + cas_write_latency;

  // ----------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------
  logic [dbbr_pkg::NUM_BANKS-1:0] act_vec;
  logic [dbbr_pkg::NUM_BANKS-1:0] pre_vec;
  logic ap_fire;
  logic [dbbr_pkg::BANK_W-1:0] ap_bank_reg;
  logic ap_pending_reg;
  logic refresh_done;

  assign bank_sel = dbbr_pkg::NUM_BANKS'(1) << bank_addr;
  assign act_vec = cmd_act ? bank_sel : '0;
  // Precharge hits one bank or all; idle or closing banks simply restart.
  assign pre_vec = (cmd_pre ? (pre_all ? '1 : bank_sel) : '0) |
                   (ap_fire ? dbbr_pkg::NUM_BANKS'(1) << ap_bank_reg : '0);

  for (genvar b = 0; b < dbbr_pkg::NUM_BANKS; b++) begin : g_bank
    dbbr_bank u_bank (
      .clock(clock),
      .reset(reset),
      .activate(act_vec[b]),
      .precharge(pre_vec[b]),
      .force_idle(refresh_done),
      .row_in(addr),
      .is_open(bank_open_w[b]),
      .is_ready(bank_ready[b]),
      .open_row(open_rows[b])
    );
  end

  // ----------------------------------------------------------------
  // Burst engine and refresh state machine
  // ----------------------------------------------------------------
  logic [dbbr_pkg::TIMER_W-1:0] timer_reg;
  logic [dbbr_pkg::TIMER_W-1:0] timer_next;
  logic [3:0] beats_reg;
  logic [dbbr_pkg::LAT_W-1:0] wait_reg;
  logic burst_is_rd_reg;
  logic [dbbr_pkg::BANK_W-1:0] burst_bank_reg;
  logic [dbbr_pkg::COL_W-1:0] burst_col_reg;
  logic burst_start;
  logic beat_now;
  logic burst_last;

  // A new column command restarts the burst; back-to-back chops are legal.
  assign burst_start = (cmd_rd || cmd_wr) && state_reg != dbbr_pkg::DBBR_REFRESH;
  assign beat_now = state_reg == dbbr_pkg::DBBR_BURST && wait_reg == '0 && beats_reg != '0;
  assign burst_last = beat_now && beats_reg == 4'h1;
  assign ap_fire = burst_last && ap_pending_reg;
  assign refresh_done = state_reg == dbbr_pkg::DBBR_REFRESH && timer_reg == '0;

  // Next-state selection; refresh wins only from idle, whether or not banks are open.
  always_comb begin
    state_next = state_reg;
    timer_next = (timer_reg != '0) ? timer_reg - 8'h01 : timer_reg;
    unique case (state_reg)
      dbbr_pkg::DBBR_IDLE: begin
        if (cmd_ref) begin
          state_next = dbbr_pkg::DBBR_REFRESH;
          timer_next = dbbr_pkg::TIMER_W'(dbbr_pkg::RFC_CYCLES - 1);
        end else if (burst_start) begin
          state_next = dbbr_pkg::DBBR_BURST;
        end
      end
      dbbr_pkg::DBBR_REFRESH: begin
        if (refresh_done) begin
          state_next = dbbr_pkg::DBBR_IDLE;
        end
      end
      dbbr_pkg::DBBR_BURST: begin
        if (burst_last && !burst_start) begin
          state_next = dbbr_pkg::DBBR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= dbbr_pkg::DBBR_IDLE;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // Burst bookkeeping; A12 is dropped so it never reaches the column.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      beats_reg <= '0;
      wait_reg <= '0;
      burst_is_rd_reg <= 1'b0;
      burst_bank_reg <= '0;
      burst_col_reg <= '0;
      ap_pending_reg <= 1'b0;
      ap_bank_reg <= '0;
    end else if (burst_start) begin
      beats_reg <= burst_len;
      wait_reg <= latency;
      burst_is_rd_reg <= cmd_rd;
      burst_bank_reg <= bank_addr;
      burst_col_reg <= addr[dbbr_pkg::COL_W-1:0];
      ap_pending_reg <= auto_pre;
      ap_bank_reg <= bank_addr;
    end else begin
      if (wait_reg != '0) begin
        wait_reg <= wait_reg - 5'h01;
      end else if (beats_reg != '0) begin
        beats_reg <= beats_reg - 4'h1;
        burst_col_reg <= burst_col_reg + 10'h001;
      end
      if (ap_fire) begin
        ap_pending_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Refresh row counter
  // ----------------------------------------------------------------
  // The row comes from the counter; the address bus is not looked at.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      refresh_row <= dbbr_pkg::REFRESH_ROW_RESET;
    end else if (refresh_done) begin
      refresh_row <= refresh_row + 14'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs toward the array
  // ----------------------------------------------------------------
  // Write data is stored only at the addressed beat; a bad strobe hurts no other cell.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_bank <= '0;
      mem_row <= '0;
      mem_col <= '0;
      mem_wr_data <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      rd_timing_ok <= 1'b0;
      bank_open <= '0;
      refresh_busy <= 1'b0;
    end else begin
      mem_rd <= beat_now && burst_is_rd_reg;
      mem_wr <= beat_now && !burst_is_rd_reg;
      mem_bank <= burst_bank_reg;
      mem_row <= open_rows[burst_bank_reg];
      mem_col <= burst_col_reg;
      mem_wr_data <= wr_data;
      rd_valid <= mem_rd;
      rd_data <= rd_data_mem;
      rd_timing_ok <= mem_rd && dll_locked;
      bank_open <= bank_open_w;
      refresh_busy <= state_next == dbbr_pkg::DBBR_REFRESH;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_ref_cmd;
    state_reg == dbbr_pkg::DBBR_IDLE && cmd_ref;
  endsequence

  a_act_opens: assert property (@(posedge clock) disable iff (reset)
    cmd_act |=> bank_open_w[$past(bank_addr)] && open_rows[$past(bank_addr)] == $past(addr))
    else $error("activate did not open row");
  a_pre_closes: assert property (@(posedge clock) disable iff (reset)
    cmd_pre && pre_all |=> bank_open_w == '0)
    else $error("precharge all left a bank open");
  a_pre_restart: assert property (@(posedge clock) disable iff (reset)
    cmd_pre && !pre_all && !refresh_done |=> !bank_ready[$past(bank_addr)])
    else $error("precharge did not restart timer");
  a_ref_starts: assert property (@(posedge clock) disable iff (reset)
    s_ref_cmd |=> state_reg == dbbr_pkg::DBBR_REFRESH)
    else $error("refresh not started");
  a_ref_idle: assert property (@(posedge clock) disable iff (reset)
    refresh_done |=> bank_open_w == '0 && state_reg == dbbr_pkg::DBBR_IDLE)
    else $error("banks not idle after refresh");
  a_ref_counter: assert property (@(posedge clock) disable iff (reset)
    refresh_done |=> refresh_row == $past(refresh_row) + 14'h0001)
    else $error("refresh row not advanced");
  a_burst_len: assert property (@(posedge clock) disable iff (reset)
    burst_start && burst_mode == dbbr_pkg::BURST_OTF |=>
      beats_reg == (($past(addr[dbbr_pkg::BC_BIT])) ? 4'h8 : 4'h4))
    else $error("wrong on-the-fly burst length");
  a_fixed_eight: assert property (@(posedge clock) disable iff (reset)
    burst_start && burst_mode == dbbr_pkg::BURST_FIXED8 |=> beats_reg == 4'h8)
    else $error("fixed burst not eight");
  a_col_no_bc: assert property (@(posedge clock) disable iff (reset)
    burst_start |=> burst_col_reg == $past(addr[dbbr_pkg::COL_W-1:0]))
    else $error("column took A12");
  a_rd_latency: assert property (@(posedge clock) disable iff (reset)
    burst_start && cmd_rd |=> wait_reg == $past(additive_latency + cas_latency))
    else $error("read latency wrong");
  a_dll_gate: assert property (@(posedge clock) disable iff (reset)
    rd_timing_ok |-> $past(dll_locked))
    else $error("read timing flagged without lock");
  a_other_bank: assert property (@(posedge clock) disable iff (reset)
    ap_pending_reg && cmd_rd && state_reg == dbbr_pkg::DBBR_BURST |=> beats_reg != '0)
    else $error("read during auto precharge refused");
  a_wr_local: assert property (@(posedge clock) disable iff (reset)
    mem_wr |-> $past(!burst_is_rd_reg))
    else $error("write beat outside a write burst");
  a_no_hang: assert property (@(posedge clock) disable iff (reset)
    state_reg == dbbr_pkg::DBBR_BURST && beats_reg == '0 && !burst_start |=>
      state_reg == dbbr_pkg::DBBR_IDLE || beats_reg != '0)
    else $error("burst engine hung");

endmodule : dbbr_core

// file: dbbr_pkg.sv
// Package of constants and types for the DDR3 bank, burst and refresh core.
package dbbr_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int LAT_W = 5;
  localparam int BC_BIT = 12;
  localparam int AP_BIT = 10;

  // ----------------------------------------------------------------
  // Burst field of the mode register and burst lengths
  // ----------------------------------------------------------------
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;
  localparam logic [3:0] BURST_LEN8 = 4'h8;
  localparam logic [3:0] BURST_LEN4 = 4'h4;

  // ----------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [ROW_W-1:0] REFRESH_ROW_RESET = 14'h0000;
  localparam int T_RP_NS = 14;
  localparam int T_RFC_NS = 160;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RP_CYCLES = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFC_CYCLES = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;

  // ----------------------------------------------------------------
  // Decoded command codes: {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_REF = 4'h1;

  typedef enum logic [2:0] {
    DBBR_IDLE = 3'h1,
    DBBR_REFRESH = 3'h2,
    DBBR_BURST = 3'h4
  } dbbr_state_t;

endpackage : dbbr_pkg

// file: dbbr_bank.sv
// One bank: open row, open flag and precharge timer.
module dbbr_bank (
  input wire logic clock,
  input wire logic reset,
  input wire logic activate,
  input wire logic precharge,
  input wire logic force_idle,
  input wire logic [dbbr_pkg::ROW_W-1:0] row_in,
  output logic is_open,
  output logic is_ready,
  output logic [dbbr_pkg::ROW_W-1:0] open_row
);

  logic [dbbr_pkg::TIMER_W-1:0] rp_reg;
  logic [dbbr_pkg::TIMER_W-1:0] rp_next;

  // ----------------------------------------------------------------
  // Precharge timer
  // ----------------------------------------------------------------
  // A repeated precharge restarts the timer, so the last one counts.
  assign rp_next = precharge ? dbbr_pkg::TIMER_W'(dbbr_pkg::RP_CYCLES) :
                   (rp_reg != '0) ? rp_reg - 8'h01 : rp_reg;
  assign is_ready = (rp_reg == '0);

  // Row and open state follow the command stream.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      is_open <= 1'b0;
      open_row <= '0;
      rp_reg <= '0;
    end else begin
      rp_reg <= force_idle ? '0 : rp_next;
      if (precharge || force_idle) begin
        is_open <= 1'b0;
      end else if (activate) begin
        is_open <= 1'b1;
        open_row <= row_in;
      end
    end
  end

endmodule : dbbr_bank

// file: dbbr_ctrl_model.sv
// Behavioural memory controller that drives the command bus of the core.
module dbbr_ctrl_model (
  input wire logic clock,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [dbbr_pkg::BANK_W-1:0] bank_addr,
  output logic [dbbr_pkg::ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int last_pre = -100;
  logic [7:0] open = 8'h00;

  // The bus starts deselected with the clock enable held high.
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank_addr = 3'h0;
    addr = 14'h0000;
  end

  // Cycle count shared with the bench so latencies can be measured.
  always @(posedge clock) cyc <= cyc + 1;

  // One command for one cycle; afterwards the address lines flip so stale values never pass.
  task automatic put(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
    output int at);
    @(negedge clock);
    {cs_n, ras_n, cas_n, we_n} = c;
    bank_addr = b;
    addr = a;
    at = cyc;
    @(negedge clock);
    {cs_n, ras_n, cas_n, we_n} = {1'b1, ~c[2:0]};
    bank_addr = ~b;
    addr = ~a;
  endtask : put

  // Sends a command, first clearing what stands in its way unless told to be rude.
  task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
    input logic rude, input int gap, output int at);
    logic rw;
    rw = (c == dbbr_pkg::CMD_RD) || (c == dbbr_pkg::CMD_WR);
    if (!rude && c == dbbr_pkg::CMD_REF && open != 8'h00) begin
      put(dbbr_pkg::CMD_PRE, 3'h0, 14'h0400, at);
      open = 8'h00;
      last_pre = at;
    end
    if (!rude && c == dbbr_pkg::CMD_ACT && open[b]) begin
      put(dbbr_pkg::CMD_PRE, b, 14'h0000, at);
      open[b] = 1'b0;
      last_pre = at;
    end
    if (!rude && rw && !open[b]) begin
      put(dbbr_pkg::CMD_ACT, b, 14'h0000, at);
      open[b] = 1'b1;
    end
    // Precharge time is counted from the latest precharge of any bank, a safe superset.
    while ((c == dbbr_pkg::CMD_ACT || c == dbbr_pkg::CMD_REF) &&
      cyc < last_pre + dbbr_pkg::RP_CYCLES + 1) @(negedge clock);
    put(c, b, a, at);
    if (c == dbbr_pkg::CMD_ACT) open[b] = 1'b1;
    if (c == dbbr_pkg::CMD_PRE) begin
      if (a[10]) open = 8'h00;
      else open[b] = 1'b0;
      last_pre = at;
    end
    if (rw && a[10]) begin
      open[b] = 1'b0;
      last_pre = at + 24; // Auto precharge lands after the burst; wait it out generously.
    end
    // Refreshes go out one per request, never postponed, then only deselects for tRFC.
    if (c == dbbr_pkg::CMD_REF) repeat (dbbr_pkg::RFC_CYCLES + 2) @(negedge clock);
    repeat (gap) @(negedge clock);
  endtask : send
endmodule : dbbr_ctrl_model

// file: ddr3_bank_burst_refresh_bench.sv
// Self-checking bench for the DDR3 bank, burst and refresh core.
module ddr3_bank_burst_refresh_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic w;
    logic [2:0] b;
    logic [13:0] r;
    logic [9:0] c;
    logic [15:0] d;
    int at;
  } dbbr_note_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, dll_locked = 1'b1;
  logic [2:0] bank_addr, mem_bank;
  logic [13:0] addr, refresh_row, mem_row;
  logic [1:0] burst_mode = 2'h1;
  logic [4:0] cas_latency = 5'h05, cas_write_latency = 5'h05, additive_latency = 5'h00;
  logic [15:0] wr_data = 16'h0000, rd_data_mem, mem_wr_data, rd_data, pend_data;
  logic [7:0] bank_open, exp_open = 8'h00;
  logic refresh_busy, mem_rd, mem_wr, rd_valid, rd_timing_ok, pend_dll, pend_rd = 1'b0;
  logic [9:0] mem_col;
  logic [31:0] lfsr = 32'h104b;
  logic [13:0] row_of [8];
  int num_errors = 0;
  int comparisons = 0;
  int busy_len = 0;
  dbbr_note_t notes[$];

  // The array answers with a word built from the beat address.
  assign rd_data_mem = {mem_bank, mem_col, 3'h5};

  initial forever #2 clock = ~clock;

  dbbr_ctrl_model dbbr_ctrl_model_inst (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr));

  dbbr_core dbbr_core_inst (.clock(clock), .reset(reset), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
    .burst_mode(burst_mode), .cas_latency(cas_latency), .cas_write_latency(cas_write_latency),
    .additive_latency(additive_latency), .dll_locked(dll_locked), .wr_data(wr_data),
    .rd_data_mem(rd_data_mem), .bank_open(bank_open), .refresh_busy(refresh_busy),
    .refresh_row(refresh_row), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_bank(mem_bank),
    .mem_row(mem_row), .mem_col(mem_col), .mem_wr_data(mem_wr_data), .rd_valid(rd_valid),
    .rd_timing_ok(rd_timing_ok), .rd_data(rd_data));

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Each beat is matched against the oldest note; a beat with no note is a fault.
  always @(negedge clock) begin
    dbbr_note_t n;
    if (!reset) begin
      check("rd_valid", rd_valid, pend_rd);
      if (pend_rd) begin
        check("rd_data", rd_data, pend_data);
        check("rd_timing_ok", rd_timing_ok, pend_dll);
      end
      pend_rd = 1'b0;
      if (mem_rd || mem_wr) begin
        if (notes.size() == 0) check("stray beat", 1'b1, 1'b0);
        else begin
          n = notes.pop_front();
          check("beat kind", mem_wr, n.w);
          check("beat bank", mem_bank, n.b);
          check("beat row", mem_row, n.r);
          check("beat col", mem_col, n.c);
          check("beat cycle", dbbr_ctrl_model_inst.cyc, n.at);
          if (n.w) check("beat data", mem_wr_data, n.d);
          pend_rd = mem_rd;
          pend_data = {n.b, n.c, 3'h5};
          pend_dll = dll_locked;
        end
      end
      if (refresh_busy) busy_len++;
      else if (busy_len != 0) begin
        check("refresh span", busy_len, dbbr_pkg::RFC_CYCLES);
        busy_len = 0;
      end
    end
  end

  // Opens a random row; the slow gap exercises a lazy controller.
  task automatic act(input logic [2:0] b);
    int at;
    lfsr = step(lfsr);
    row_of[b] = lfsr[13:0];
    dbbr_ctrl_model_inst.send(dbbr_pkg::CMD_ACT, b, row_of[b], 1'b0, 3, at);
    exp_open[b] = 1'b1;
  endtask : act

  task automatic pre(input logic [2:0] b, input logic all);
    int at;
    dbbr_ctrl_model_inst.send(dbbr_pkg::CMD_PRE, b, {3'h0, all, 10'h155}, 1'b0, 0, at);
    if (all) exp_open = 8'h00;
    else exp_open[b] = 1'b0;
  endtask : pre

  // Notes every beat before the first one can appear; spare address bits are random.
  task automatic burst(input logic w, input logic [2:0] b, input logic a12, input logic ap,
    input int gap);
    int at;
    int len;
    int lat;
    logic [13:0] a;
    lfsr = step(lfsr);
    a = {lfsr[20], a12, lfsr[21], ap, lfsr[9:3], 3'h0};
    len = (burst_mode == 2'h2 || (burst_mode == 2'h1 && !a12)) ? 4 : 8;
    lat = additive_latency + (w ? cas_write_latency : cas_latency);
    if (w) wr_data = lfsr[31:16];
    dbbr_ctrl_model_inst.send(w ? dbbr_pkg::CMD_WR : dbbr_pkg::CMD_RD, b, a, 1'b0, 0, at);
    for (int i = 0; i < len; i++) notes.push_back('{w, b, row_of[b], a[9:0] + i, wr_data,
      at + lat + 2 + i});
    if (ap) exp_open[b] = 1'b0;
    repeat (gap) @(negedge clock);
  endtask : burst

  task automatic settle();
    int k;
    for (k = 0; k < 300 && (notes.size() != 0 || refresh_busy !== 1'b0); k++) @(negedge clock);
    repeat (4) @(negedge clock);
    check("bank_open", bank_open, exp_open);
    check("drained", k < 300, 1'b1);
  endtask : settle

  // The address bus carries noise during refresh; the internal counter must step anyway.
  task automatic refresh();
    int at;
    logic [13:0] row0;
    row0 = refresh_row;
    lfsr = step(lfsr);
    dbbr_ctrl_model_inst.send(dbbr_pkg::CMD_REF, lfsr[2:0], lfsr[29:16], 1'b0, 0, at);
    exp_open = 8'h00;
    settle();
    check("refresh_row", refresh_row, row0 + 14'h0001);
  endtask : refresh

  initial begin
    int at;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check("reset row", refresh_row, dbbr_pkg::REFRESH_ROW_RESET);
    for (int b = 0; b < 8; b++) act(b[2:0]);
    settle();
    // Every burst mode with A12 low and high, reads and writes, two latency settings.
    for (int l = 0; l < 2; l++) begin
      additive_latency = l ? 5'h04 : 5'h00;
      cas_latency = l ? 5'h06 : 5'h05;
      for (int m = 0; m < 3; m++) begin
        burst_mode = m[1:0];
        for (int k = 0; k < 4; k++) burst(k[0], 3'(m + k), k[1], 1'b0, 20);
        settle();
      end
    end
    burst_mode = 2'h1;
    additive_latency = 5'h00;
    cas_latency = 5'h05;
    // A new column command restarts the engine, so each waits for the previous last beat.
    for (int i = 0; i < 4; i++) burst(1'b0, 3'(i), 1'b0, 1'b0, 8);
    settle();
    burst(1'b0, 3'h0, 1'b1, 1'b1, 12);
    burst(1'b0, 3'h1, 1'b1, 1'b0, 12);
    settle();
    dbbr_ctrl_model_inst.send(dbbr_pkg::CMD_RD, 3'h0, 14'h0008, 1'b1, 0, at);
    settle();
    dll_locked = 1'b0;
    burst(1'b0, 3'h1, 1'b1, 1'b0, 0);
    settle();
    dll_locked = 1'b1;
    pre(3'h1, 1'b0);
    pre(3'h1, 1'b0);
    act(3'h0);
    settle();
    pre(3'h0, 1'b1);
    settle();
    act(3'h2);
    act(3'h6);
    refresh();
    refresh();
    close_out();
  end

  // Watchdog far beyond the fewer than one thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    close_out();
  end
endmodule : ddr3_bank_burst_refresh_bench
